//--- lpm_loop_words.sv
`timescale 1ns/100ps
// How it works
// - A 0-to-1 write on setting-one bit 0, 1 or 2 requests manual, auto, cascade.
// - Setting-one bit 3 selects bumpless transfer method one or two.
// - Setting-one bit 4 selects direct or reverse acting control.
// - Setting-one bit 5 selects position or velocity algorithm.
// - Setting-one bit 6 selects linear or square-root process value.
// - Setting-one bit 7 selects linear or squared error.
// - Setting-one bits 8-10 enable deadband, derivative limit, integrator freeze.
// - Setting-one bits 11-14 enable ramp/soak, absolute, deviation, rate alarms.
// - Setting-one bit 15 set makes the loop run independent of controller mode.
// - Setting-two bit 0 picks unipolar/bipolar, bit 1 picks 12/15-bit format.
// - Setting-two bit 9 forces 16-bit unipolar and overrides bits 0 and 1.
// - Setting-two bit 10 separates output format into bits 11 to 13.
// - Separate output: bit 11 range, bit 12 width, bit 13 forces 16-bit unipolar.
// - Setting-two bit 4 selects integral units seconds or minutes.
// - Setting-two bits 5 and 6 select tuning method and tuned terms.
// - Software sets setting-two bit 7 to tune; device clears it when done.
// - Setting-two bit 3 enables set point limiting.
// - Setting-two bit 8 is read-only scan clock; bits 14 and 15 reserved.
// - Status bits 0-2 show active manual, auto, cascade mode.
// - Status bits 3-9 show the process value alarms while they hold and their monitor is enabled.
// - Status bit 10 flags bad alarm programming, bit 11 calculation overflow.
// - Status bit 12 shows tuning running, bit 13 tuning failed; 14-15 reserved.
module lpm_loop_words #(
	parameter int ADDR_W = 5
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Loop table word port.
	input wire logic [ADDR_W-1:0] word_addr,
	input wire logic word_wr,
	input wire logic word_rd,
	input wire logic [15:0] word_wdata,
	output logic [15:0] word_rdata,
	// Loop engine state.
	input wire logic cpu_run,
	input wire logic scan_clock,
	input wire logic [6:0] alarm_cond,
	input wire logic alarm_prog_err,
	input wire logic calc_ovf,
	input wire logic tune_done,
	input wire logic tune_fail,
	// Mode and algorithm controls.
	output logic [2:0] mode_active,
	output logic loop_run,
	output logic bumpless_two,
	output logic reverse_act,
	output logic velocity_form,
	output logic process_value_sqrt,
	output logic err_squared,
	output logic deadband_en,
	output logic dgain_limit_en,
	output logic bias_freeze,
	output logic ramp_soak_en,
	// Data formats.
	output logic in_bipolar,
	output logic [1:0] in_fmt,
	output logic out_bipolar,
	output logic [1:0] out_fmt,
	// Setting word two controls.
	output logic filter_en,
	output logic set_point_limit_en,
	output logic reset_minutes,
	output logic tune_open_loop,
	output logic tune_pi_only,
	output logic tune_start
);
	// Below three address bits the status word at index six cannot be reached.
	if (ADDR_W < 3)
	begin : g_addr_check
		$error("ADDR_W too small to reach the status word");
	end

	logic [15:0] setting_one;
	logic [15:0] setting_two;
	logic [15:0] alarm_status;
	logic scan_sample;
	logic tune_err;
	lpm_mode_if mode_bus ();

	// Address decode against the printed word indices.
	wire logic [4:0] addr_idx = 5'(word_addr);
	wire logic hit_one = (addr_idx == lpm_pkg::OFS_SETTING_ONE);
	wire logic hit_two = (addr_idx == lpm_pkg::OFS_SETTING_TWO);
	wire logic hit_status = (addr_idx == lpm_pkg::OFS_ALARM_STATUS);
	wire logic wr_one = word_wr & hit_one;
	wire logic wr_two = word_wr & hit_two;

	// Only a fresh 0-to-1 edge requests; rewriting a held 1 does nothing.
	assign mode_bus.req = wr_one ? (word_wdata[2:0] & ~setting_one[2:0]) : 3'h0;
	assign mode_active = mode_bus.active;

	lpm_mode_ctl u_mode_ctl (
		.clk(clk),
		.reset_n(reset_n),
		.mode(mode_bus.ctl)
	);

	// Tune start: a software write wins over the end of tuning in the same cycle.
	wire logic tune_end = tune_done | tune_fail;
	wire logic next_tune_bit = wr_two ? word_wdata[lpm_pkg::S2_TUNE_START] :
		(setting_two[lpm_pkg::S2_TUNE_START] & ~tune_end);
	wire logic tune_rise = wr_two & word_wdata[lpm_pkg::S2_TUNE_START] &
		~setting_two[lpm_pkg::S2_TUNE_START];
	wire logic [15:0] next_setting_two = wr_two ?
		((word_wdata & lpm_pkg::S2_WRITE_MASK) & ~(16'h0001 << lpm_pkg::S2_TUNE_START)) |
		(16'(next_tune_bit) << lpm_pkg::S2_TUNE_START) :
		((setting_two & ~(16'h0001 << lpm_pkg::S2_TUNE_START)) |
		(16'(next_tune_bit) << lpm_pkg::S2_TUNE_START));

	// Setting one holds what software wrote; setting two holds the writable bits, its tune bit cleared when tuning ends.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			setting_one <= lpm_pkg::SETTING_ONE_RESET;
			setting_two <= lpm_pkg::SETTING_TWO_RESET;
		end
		else
		begin
			if (wr_one)
				setting_one <= word_wdata;
			setting_two <= next_setting_two;
		end
	end

	// A failure sticks until the next start; a failure in the start cycle still sticks.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			tune_err <= 1'b0;
		else if (tune_fail)
			tune_err <= 1'b1;
		else if (tune_rise)
			tune_err <= 1'b0;
	end

	// Alarm bits are only reported while their monitor is enabled.
	wire logic [3:0] value_alarms = alarm_cond[3:0] &
		{4{setting_one[lpm_pkg::S1_VALUE_ALARM]}};
	wire logic [1:0] dev_alarms = alarm_cond[5:4] & {2{setting_one[lpm_pkg::S1_DEV_ALARM]}};
	wire logic rate_alarm = alarm_cond[6] & setting_one[lpm_pkg::S1_RATE_ALARM];
	wire logic [15:0] next_status = {2'b00, tune_err,
		setting_two[lpm_pkg::S2_TUNE_START], calc_ovf, alarm_prog_err,
		rate_alarm, dev_alarms, value_alarms, mode_bus.active};

	// The status word is rebuilt every cycle from the engine's levels.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			alarm_status <= {13'h0000, lpm_pkg::MODE_RESET};
			scan_sample <= 1'b0;
		end
		else
		begin
			alarm_status <= next_status;
			scan_sample <= scan_clock;
		end
	end

	// Read mux; unmapped words read as zero.
	wire logic [15:0] two_view = setting_two |
		(16'(scan_sample) << lpm_pkg::S2_SCAN_CLOCK);
	wire logic [15:0] next_rdata = hit_one ? setting_one :
		(hit_two ? two_view : (hit_status ? alarm_status : 16'h0000));

	// Read data is registered so it is stable the cycle after the strobe.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			word_rdata <= 16'h0000;
		else if (word_rd)
			word_rdata <= next_rdata;
	end

	// Format decode: input always from 0/1/9; output from 11-13 only when separated.
	wire logic sep = setting_two[lpm_pkg::S2_SEPARATE];
	wire logic dec_in_bip;
	wire logic [1:0] dec_in_fmt;
	wire logic dec_out_bip;
	wire logic [1:0] dec_out_fmt;

	lpm_format_decode u_in_fmt (
		.bipolar_sel(setting_two[lpm_pkg::S2_IN_BIPOLAR]),
		.fmt15_sel(setting_two[lpm_pkg::S2_IN_FMT15]),
		.fmt16_sel(setting_two[lpm_pkg::S2_IN_FMT16]),
		.bipolar(dec_in_bip),
		.fmt(dec_in_fmt)
	);

	lpm_format_decode u_out_fmt (
		.bipolar_sel(sep ? setting_two[lpm_pkg::S2_OUT_BIPOLAR] :
			setting_two[lpm_pkg::S2_IN_BIPOLAR]),
		.fmt15_sel(sep ? setting_two[lpm_pkg::S2_OUT_FMT15] :
			setting_two[lpm_pkg::S2_IN_FMT15]),
		.fmt16_sel(sep ? setting_two[lpm_pkg::S2_OUT_FMT16] :
			setting_two[lpm_pkg::S2_IN_FMT16]),
		.bipolar(dec_out_bip),
		.fmt(dec_out_fmt)
	);

	// Control outputs are registered from the setting fields; the formats are decoded and loop_run also follows cpu_run.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			{in_bipolar, in_fmt, out_bipolar, out_fmt} <= '0;
			{loop_run, bumpless_two, reverse_act, velocity_form, process_value_sqrt} <= '0;
			{err_squared, deadband_en, dgain_limit_en, bias_freeze} <= '0;
			{ramp_soak_en, filter_en, set_point_limit_en, reset_minutes} <= '0;
			{tune_open_loop, tune_pi_only, tune_start} <= '0;
		end
		else
		begin
			in_bipolar <= dec_in_bip;
			in_fmt <= dec_in_fmt;
			out_bipolar <= dec_out_bip;
			out_fmt <= dec_out_fmt;
			loop_run <= cpu_run | setting_one[lpm_pkg::S1_INDEPENDENT];
			bumpless_two <= setting_one[lpm_pkg::S1_BUMPLESS];
			reverse_act <= setting_one[lpm_pkg::S1_REVERSE];
			velocity_form <= setting_one[lpm_pkg::S1_VELOCITY];
			process_value_sqrt <= setting_one[lpm_pkg::S1_VALUE_SQRT];
			err_squared <= setting_one[lpm_pkg::S1_ERR_SQUARED];
			deadband_en <= setting_one[lpm_pkg::S1_DEADBAND];
			dgain_limit_en <= setting_one[lpm_pkg::S1_DGAIN_LIMIT];
			bias_freeze <= setting_one[lpm_pkg::S1_BIAS_FREEZE];
			ramp_soak_en <= setting_one[lpm_pkg::S1_RAMP_SOAK];
			filter_en <= setting_two[lpm_pkg::S2_FILTER];
			set_point_limit_en <= setting_two[lpm_pkg::S2_SET_POINT_LIMIT];
			reset_minutes <= setting_two[lpm_pkg::S2_RESET_MIN];
			tune_open_loop <= setting_two[lpm_pkg::S2_TUNE_OPEN];
			tune_pi_only <= setting_two[lpm_pkg::S2_TUNE_PI];
			tune_start <= setting_two[lpm_pkg::S2_TUNE_START];
		end
	end

	// Checks on the block's own behaviour.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_mode_onehot;
		$onehot(mode_active);
	endproperty
	a_mode_onehot: assert property (p_mode_onehot) else $error("mode not one-hot");

	property p_manual_req;
		wr_one && word_wdata[0] && !setting_one[0] |=> mode_active == 3'h1;
	endproperty
	a_manual_req: assert property (p_manual_req) else $error("manual request lost");

	property p_static_level;
		wr_one && ((word_wdata[2:0] & ~setting_one[2:0]) == 3'h0) |=> $stable(mode_active);
	endproperty
	a_static_level: assert property (p_static_level) else $error("level re-requested");

	property p_tune_clear;
		setting_two[7] && tune_done && !wr_two |=> !setting_two[7] ##1 !tune_start;
	endproperty
	a_tune_clear: assert property (p_tune_clear) else $error("tune bit not cleared");

	property p_in_16;
		setting_two[9] |=> in_fmt == lpm_pkg::FMT_16 && !in_bipolar;
	endproperty
	a_in_16: assert property (p_in_16) else $error("16-bit input not unipolar");

	property p_same_fmt;
		!setting_two[10] |=> out_fmt == in_fmt && out_bipolar == in_bipolar;
	endproperty
	a_same_fmt: assert property (p_same_fmt) else $error("output format differs");

	property p_out_16;
		setting_two[10] && setting_two[13] |=> out_fmt == lpm_pkg::FMT_16 && !out_bipolar;
	endproperty
	a_out_16: assert property (p_out_16) else $error("16-bit output not unipolar");

	property p_alarm_gate;
		!setting_one[12] |=> alarm_status[6:3] == 4'h0;
	endproperty
	a_alarm_gate: assert property (p_alarm_gate) else $error("disabled alarm reported");

	property p_tune_run;
		setting_two[7] |=> alarm_status[12];
	endproperty
	a_tune_run: assert property (p_tune_run) else $error("tune run not shown");

	property p_reserved;
		word_rd && !hit_one |=> word_rdata[15:14] == 2'b00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

	property p_auto_req;
		wr_one && word_wdata[1] && !setting_one[1] && !(word_wdata[0] && !setting_one[0])
			|=> mode_active == 3'h2;
	endproperty
	a_auto_req: assert property (p_auto_req) else $error("auto request lost");

	property p_mode_status;
		1'b1 |=> alarm_status[2:0] == $past(mode_active);
	endproperty
	a_mode_status: assert property (p_mode_status) else $error("status mode wrong");

	property p_level_alarms;
		setting_one[12] |=> alarm_status[6:3] == $past(alarm_cond[3:0]);
	endproperty
	a_level_alarms: assert property (p_level_alarms) else $error("level alarm wrong");

	property p_dev_alarms;
		setting_one[13] |=> alarm_status[8:7] == $past(alarm_cond[5:4]);
	endproperty
	a_dev_alarms: assert property (p_dev_alarms) else $error("deviation alarm wrong");

	property p_rate_alarm;
		setting_one[14] |=> alarm_status[9] == $past(alarm_cond[6]);
	endproperty
	a_rate_alarm: assert property (p_rate_alarm) else $error("rate alarm wrong");

	property p_error_flags;
		1'b1 |=> alarm_status[10] == $past(alarm_prog_err) && alarm_status[11] == $past(calc_ovf);
	endproperty
	a_error_flags: assert property (p_error_flags) else $error("error flags wrong");

	property p_fail_sticks;
		tune_fail |-> ##2 alarm_status[13];
	endproperty
	a_fail_sticks: assert property (p_fail_sticks) else $error("tune failure not shown");

	property p_independent;
		setting_one[15] |=> loop_run;
	endproperty
	a_independent: assert property (p_independent) else $error("independent loop stopped");

	property p_follow_cpu;
		!setting_one[15] |=> loop_run == $past(cpu_run);
	endproperty
	a_follow_cpu: assert property (p_follow_cpu) else $error("loop not following run");

	property p_limit_copy;
		1'b1 |=> set_point_limit_en == $past(setting_two[lpm_pkg::S2_SET_POINT_LIMIT]);
	endproperty
	a_limit_copy: assert property (p_limit_copy) else $error("set point limit wrong");
endmodule : lpm_loop_words

//--- lpm_pkg.sv
package lpm_pkg;
	// Word indices inside one loop's parameter table.
	localparam logic [4:0] OFS_SETTING_ONE = 5'h00;
	localparam logic [4:0] OFS_SETTING_TWO = 5'h01;
	localparam logic [4:0] OFS_ALARM_STATUS = 5'h06;
	localparam int WORD_W = 16;
	// Setting word one fields.
	localparam int S1_MANUAL_REQ = 0;
	localparam int S1_BUMPLESS = 3;
	localparam int S1_REVERSE = 4;
	localparam int S1_VELOCITY = 5;
	localparam int S1_VALUE_SQRT = 6;
	localparam int S1_ERR_SQUARED = 7;
	localparam int S1_DEADBAND = 8;
	localparam int S1_DGAIN_LIMIT = 9;
	localparam int S1_BIAS_FREEZE = 10;
	localparam int S1_RAMP_SOAK = 11;
	localparam int S1_VALUE_ALARM = 12;
	localparam int S1_DEV_ALARM = 13;
	localparam int S1_RATE_ALARM = 14;
	localparam int S1_INDEPENDENT = 15;
	// Setting word two fields.
	localparam int S2_IN_BIPOLAR = 0;
	localparam int S2_IN_FMT15 = 1;
	localparam int S2_FILTER = 2;
	localparam int S2_SET_POINT_LIMIT = 3;
	localparam int S2_RESET_MIN = 4;
	localparam int S2_TUNE_OPEN = 5;
	localparam int S2_TUNE_PI = 6;
	localparam int S2_TUNE_START = 7;
	localparam int S2_SCAN_CLOCK = 8;
	localparam int S2_IN_FMT16 = 9;
	localparam int S2_SEPARATE = 10;
	localparam int S2_OUT_BIPOLAR = 11;
	localparam int S2_OUT_FMT15 = 12;
	localparam int S2_OUT_FMT16 = 13;
	// Bits of setting word two that software may write.
	localparam logic [15:0] S2_WRITE_MASK = 16'h3eff;
	// Status word fields.
	localparam int ST_MODE = 0;
	localparam int ST_VALUE_ALARM = 3;
	localparam int ST_DEV_ALARM = 7;
	localparam int ST_RATE_ALARM = 9;
	localparam int ST_PROG_ERR = 10;
	localparam int ST_CALC_OVF = 11;
	localparam int ST_TUNE_RUN = 12;
	localparam int ST_TUNE_ERR = 13;
	// Reset values.
	localparam logic [15:0] SETTING_ONE_RESET = 16'h0000;
	localparam logic [15:0] SETTING_TWO_RESET = 16'h0000;
	localparam logic [2:0] MODE_RESET = 3'h1;
	// Data format codes.
	localparam logic [1:0] FMT_12 = 2'h0;
	localparam logic [1:0] FMT_15 = 2'h1;
	localparam logic [1:0] FMT_16 = 2'h2;
endpackage : lpm_pkg

//--- lpm_mode_if.sv
`timescale 1ns/100ps
interface lpm_mode_if;
	// One-cycle request pulses: manual, automatic, cascade.
	logic [2:0] req;
	// One-hot active mode, same bit order.
	logic [2:0] active;
	modport ctl (input req, output active);
	modport host (output req, input active);
endinterface : lpm_mode_if

//--- lpm_mode_ctl.sv
`timescale 1ns/100ps
module lpm_mode_ctl (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Requests in, active mode out.
	lpm_mode_if.ctl mode
);
	typedef enum logic [1:0] {LPM_MANUAL, LPM_AUTO, LPM_CASCADE} lpm_mode_t;
	lpm_mode_t state;
	lpm_mode_t next_state;

	// Manual wins when requests collide, since it is the safe fallback.
	always_comb
	begin
		case (state)
			LPM_MANUAL, LPM_AUTO, LPM_CASCADE:
			begin
				if (mode.req[0])
					next_state = LPM_MANUAL;
				else if (mode.req[1])
					next_state = LPM_AUTO;
				else if (mode.req[2])
					next_state = LPM_CASCADE;
				else
					next_state = state;
			end
			default: next_state = LPM_MANUAL;
		endcase
	end

	// The state and its one-hot indication change together.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= LPM_MANUAL;
			mode.active <= lpm_pkg::MODE_RESET;
		end
		else
		begin
			state <= next_state;
			mode.active <= 3'h1 << next_state;
		end
	end
endmodule : lpm_mode_ctl

//--- lpm_format_decode.sv
`timescale 1ns/100ps
module lpm_format_decode (
	// Raw format bits.
	input wire logic bipolar_sel,
	input wire logic fmt15_sel,
	input wire logic fmt16_sel,
	// Resolved format.
	output logic bipolar,
	output logic [1:0] fmt
);
	// The 16-bit choice overrides the other two and is always unipolar.
	assign bipolar = bipolar_sel & ~fmt16_sel;
	assign fmt = fmt16_sel ? lpm_pkg::FMT_16 :
		(fmt15_sel ? lpm_pkg::FMT_15 : lpm_pkg::FMT_12);
endmodule : lpm_format_decode

//--- testbench.sv
`timescale 1ns/100ps
module testbench;
	// Clock, reset and the loop table word port.
	logic clk, reset_n, word_wr, word_rd, rd_q;
	logic [4:0] word_addr;
	logic [15:0] word_wdata, word_rdata;
	// Loop engine state driven by the bench.
	logic cpu_run, scan_clock, alarm_prog_err, calc_ovf, tune_done, tune_fail;
	logic [6:0] alarm_cond;
	// Control outputs of the block.
	logic [2:0] mode_active;
	logic loop_run, bumpless_two, reverse_act, velocity_form, process_value_sqrt, err_squared;
	logic deadband_en, dgain_limit_en, bias_freeze, ramp_soak_en, in_bipolar, out_bipolar;
	logic [1:0] in_fmt, out_fmt;
	logic filter_en, set_point_limit_en, reset_minutes, tune_open_loop, tune_pi_only, tune_start;
	// Bench model of the stored words and the expected read results.
	logic [15:0] exp_s1, exp_s2, exp_q[$];
	logic [2:0] exp_mode;
	logic tune_err;
	int n_mismatch, total_checks, cycles;

	lpm_loop_words i_lpm_loop_words (.clk(clk), .reset_n(reset_n), .word_addr(word_addr),
		.word_wr(word_wr), .word_rd(word_rd), .word_wdata(word_wdata), .word_rdata(word_rdata),
		.cpu_run(cpu_run), .scan_clock(scan_clock), .alarm_cond(alarm_cond),
		.alarm_prog_err(alarm_prog_err), .calc_ovf(calc_ovf), .tune_done(tune_done),
		.tune_fail(tune_fail), .mode_active(mode_active), .loop_run(loop_run),
		.bumpless_two(bumpless_two), .reverse_act(reverse_act), .velocity_form(velocity_form),
		.process_value_sqrt(process_value_sqrt), .err_squared(err_squared),
		.deadband_en(deadband_en),
		.dgain_limit_en(dgain_limit_en), .bias_freeze(bias_freeze), .ramp_soak_en(ramp_soak_en),
		.in_bipolar(in_bipolar), .in_fmt(in_fmt), .out_bipolar(out_bipolar), .out_fmt(out_fmt),
		.filter_en(filter_en), .set_point_limit_en(set_point_limit_en),
		.reset_minutes(reset_minutes), .tune_open_loop(tune_open_loop),
		.tune_pi_only(tune_pi_only), .tune_start(tune_start));

	// Free running clock at 125 MHz.
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	// A hung handshake must not stall the run forever.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			$display("ERROR %0t: run did not finish in time", $time);
			give_verdict();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// Read data lands one cycle after the strobe, so the oldest note is taken then.
	always @(posedge clk) rd_q <= word_rd;
	always @(negedge clk)
	begin
		if (rd_q)
		begin
			total_checks++;
			if (exp_q.size() == 0)
			begin
				n_mismatch++;
				$display("ERROR %0t: read data with no expected value", $time);
			end
			else if (word_rdata !== exp_q[0])
			begin
				n_mismatch++;
				$display("ERROR %0t: read got %h expected %h", $time, word_rdata, exp_q[0]);
			end
			if (exp_q.size() != 0)
				void'(exp_q.pop_front());
		end
	end

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle

	// One write strobe; returns once the derived outputs have settled.
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk);
		word_addr = a;
		word_wdata = d;
		word_wr = 1'b1;
		@(negedge clk);
		word_wr = 1'b0;
		@(negedge clk);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(negedge clk);
		word_addr = a;
		word_rd = 1'b1;
		exp_q.push_back(e);
		@(negedge clk);
		word_rd = 1'b0;
	endtask : rd

	function automatic logic [15:0] st_exp();
		logic [6:0] en;
		en = {exp_s1[14], {2{exp_s1[13]}}, {4{exp_s1[12]}}};
		return {2'b00, tune_err, exp_s2[7], calc_ovf, alarm_prog_err, alarm_cond & en, exp_mode};
	endfunction : st_exp

	// Expected {out range, out format, in range, in format} from a setting two value.
	function automatic logic [5:0] fmt_exp(input logic [15:0] v);
		logic ib, ob;
		logic [1:0] ifm, ofm;
		ib = v[9] ? 1'b0 : v[0];
		ifm = v[9] ? lpm_pkg::FMT_16 : (v[1] ? lpm_pkg::FMT_15 : lpm_pkg::FMT_12);
		ob = v[13] ? 1'b0 : v[11];
		ofm = v[13] ? lpm_pkg::FMT_16 : (v[12] ? lpm_pkg::FMT_15 : lpm_pkg::FMT_12);
		if (!v[10])
		begin
			ob = ib;
			ofm = ifm;
		end
		return {ob, ofm, ib, ifm};
	endfunction : fmt_exp

	// Only a 0-to-1 step on a request bit asks for a mode; manual wins a collision.
	task automatic wr_s1(input logic [15:0] v);
		logic [2:0] req;
		req = v[2:0] & ~exp_s1[2:0];
		if (req[0])
			exp_mode = 3'h1;
		else if (req[1])
			exp_mode = 3'h2;
		else if (req[2])
			exp_mode = 3'h4;
		exp_s1 = v;
		wr(lpm_pkg::OFS_SETTING_ONE, v);
		chk({13'h0000, mode_active}, {13'h0000, exp_mode}, "active mode");
		chk({7'h00, ramp_soak_en, bias_freeze, dgain_limit_en, deadband_en, err_squared,
			process_value_sqrt, velocity_form, reverse_act, bumpless_two},
			{7'h00, v[11:3]}, "options");
		chk({15'h0000, loop_run}, {15'h0000, cpu_run | v[15]}, "loop run");
	endtask : wr_s1

	// A fresh tuning start clears an old tuning error.
	task automatic wr_s2(input logic [15:0] v);
		if (v[7] && !exp_s2[7])
			tune_err = 1'b0;
		exp_s2 = v & lpm_pkg::S2_WRITE_MASK;
		wr(lpm_pkg::OFS_SETTING_TWO, v);
		chk({10'h000, out_bipolar, out_fmt, in_bipolar, in_fmt}, {10'h000, fmt_exp(v)},
			"formats");
		chk({10'h000, tune_start, tune_pi_only, tune_open_loop, reset_minutes, set_point_limit_en,
			filter_en}, {10'h000, exp_s2[7:2]}, "setting two");
	endtask : wr_s2

	// Pulses the end of tuning, ok or failed.
	task automatic tune_end(input logic failed);
		@(negedge clk);
		tune_done = !failed;
		tune_fail = failed;
		@(negedge clk);
		tune_done = 1'b0;
		tune_fail = 1'b0;
		exp_s2[7] = 1'b0;
		tune_err = tune_err | failed;
		idle(2);
		chk({15'h0000, tune_start}, 16'h0000, "tune start after end");
		rd(lpm_pkg::OFS_ALARM_STATUS, st_exp());
	endtask : tune_end

	initial
	begin
		logic [15:0] v;
		logic [15:0] modes[8];
		modes = '{16'h0002, 16'h0002, 16'h0000, 16'h0004, 16'h0001, 16'h0006, 16'h0000,
			16'h0006};
		{reset_n, word_wr, word_rd, word_addr, word_wdata} = '0;
		{cpu_run, scan_clock, alarm_prog_err, calc_ovf, tune_done, tune_fail, alarm_cond} = '0;
		{exp_s1, exp_s2, tune_err, n_mismatch, total_checks, cycles} = '0;
		exp_mode = lpm_pkg::MODE_RESET;
		void'($urandom(90));
		repeat (12) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		// Reset values, unmapped reads and a refused write to the status word.
		chk({13'h0000, mode_active}, 16'h0001, "reset mode");
		rd(lpm_pkg::OFS_ALARM_STATUS, 16'h0001);
		rd(lpm_pkg::OFS_SETTING_ONE, 16'h0000);
		rd(5'h02, 16'h0000);
		rd(5'h1f, 16'h0000);
		wr(lpm_pkg::OFS_ALARM_STATUS, 16'hffff);
		rd(lpm_pkg::OFS_ALARM_STATUS, st_exp());
		// Mode requests: repeats, releases and a collision.
		foreach (modes[i])
		begin
			wr_s1(modes[i]);
			rd(lpm_pkg::OFS_ALARM_STATUS, st_exp());
		end
		// Random options, alarm enables and alarm conditions.
		repeat (16)
		begin
			cpu_run = 1'($urandom);
			wr_s1(16'($urandom) & 16'hfff8);
			{alarm_cond, alarm_prog_err, calc_ovf} = 9'($urandom);
			idle(2);
			rd(lpm_pkg::OFS_ALARM_STATUS, st_exp());
		end
		// Every combination of the format selects.
		for (int i = 0; i < 128; i++)
		begin
			v = {2'b00, i[6:3], i[2], 1'b0, 1'b0, 5'($urandom), i[1:0]};
			wr_s2(v);
		end
		// Read-only scan clock and reserved bits in setting two.
		for (int s = 0; s < 2; s++)
		begin
			scan_clock = s[0];
			wr_s2(16'hff7f);
			rd(lpm_pkg::OFS_SETTING_TWO, 16'h3e7f | {7'h00, s[0], 8'h00});
		end
		// Tuning ends well, then fails, then a restart clears the error.
		scan_clock = 1'b0;
		wr_s2(16'h0080);
		rd(lpm_pkg::OFS_ALARM_STATUS, st_exp());
		tune_end(1'b0);
		rd(lpm_pkg::OFS_SETTING_TWO, 16'h0000);
		wr_s2(16'h0080);
		tune_end(1'b1);
		wr_s2(16'h0080);
		rd(lpm_pkg::OFS_ALARM_STATUS, st_exp());
		wr_s2(16'h0000);
		rd(lpm_pkg::OFS_ALARM_STATUS, st_exp());
		// A second reset in mid-run brings every word back to its reset value.
		@(negedge clk);
		reset_n = 1'b0;
		{exp_s1, exp_s2, tune_err} = '0;
		exp_mode = lpm_pkg::MODE_RESET;
		idle(3);
		reset_n = 1'b1;
		chk({13'h0000, mode_active}, 16'h0001, "mode after reset");
		chk({15'h0000, tune_start}, 16'h0000, "tune after reset");
		rd(lpm_pkg::OFS_SETTING_TWO, 16'h0000);
		rd(lpm_pkg::OFS_ALARM_STATUS, st_exp());
		wr_s1(16'h0004);
		idle(4);
		give_verdict();
	end
endmodule : testbench
